//--- bench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import tmc_pkg::*;
    logic        hclk;          // clock
    logic        hresetn;       // reset, active low
    logic        hsel;          // select
    logic [7:0]  haddr;         // address
    logic [1:0]  htrans;        // transfer type
    logic        hwrite;        // write strobe
    logic [2:0]  hsize;         // size, word
    logic [31:0] hwdata;        // write data
    logic [31:0] hrdata;        // read data
    logic        hreadyout;     // ready
    logic        hresp;         // response
    logic        ext_pin;       // count pin
    logic        wdog_tick;     // watchdog pulse
    logic        irq;           // interrupt
    logic [31:0] rd;            // last read
    logic [7:0]  v;             // saved count
    int          error_cnt;     // mismatches
    int          total_checks;  // comparisons
    // rows: write flag, address, data or expected read
    localparam logic [40:0] ROWS [10] = '{
        {1'b0, TMC_OFF_CTRL, 32'h0000_000F}, {1'b0, TMC_OFF_STATUS, 32'h0}, {1'b0, TMC_OFF_MASK, 32'h0},
        {1'b0, 8'h14, 32'h0}, {1'b1, 8'h14, 32'hFFFF_FFFF}, {1'b0, 8'h14, 32'h0},
        {1'b1, TMC_OFF_MASK, 32'h3}, {1'b0, TMC_OFF_MASK, 32'h3},
        {1'b1, TMC_OFF_CTRL, 32'h8}, {1'b0, TMC_OFF_CTRL, 32'h8}};

    tmc_timer tmc_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .external_count_input(ext_pin), .wdog_tick(wdog_tick), .irq(irq));
    tmc_pin_model tmc_pin_model_i (.hclk(hclk), .pin(ext_pin));

    // one single ahb transfer, address then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= TMC_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // pass when lo <= g <= hi
    task automatic chkr(input string n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
        chk(n, 32'h1, {31'h0, (g >= lo && g <= hi) === 1'b1});
    endtask : chkr

    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc

    task results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // watchdog on a hung run
    initial begin
        repeat (40000) @(posedge hclk);
        error_cnt++;
        results();
    end

    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
        error_cnt = 0;
        total_checks = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ROWS[i]) begin
            if (ROWS[i][40]) xfer(1'b1, ROWS[i][39:32], ROWS[i][31:0]);
            else rdc("table read", ROWS[i][39:32], ROWS[i][31:0]);
        end
        $display("test table done");
        // timer at 1:1, hold-off after write
        xfer(1'b1, TMC_OFF_COUNT, 32'h10);
        rdc("count after write", TMC_OFF_COUNT, 32'h10);
        repeat (80) @(posedge hclk);
        xfer(1'b0, TMC_OFF_COUNT, 32'h0);
        chkr("count 1:1", 32'h21, 32'h24, rd);
        v = rd[7:0];
        xfer(1'b0, TMC_OFF_COUNT, 32'h0);
        chkr("count next read", {24'h0, v}, {24'h0, v + 8'h01}, rd);
        $display("test timer rate done");
        // every ratio, prescaler half full before the clearing write
        for (int k = 0; k < 8; k++) begin
            xfer(1'b1, TMC_OFF_CTRL, k);
            repeat (2 * (2 << k)) @(posedge hclk);
            xfer(1'b1, TMC_OFF_COUNT, 32'h0);
            repeat (8 + 14 * (2 << k)) @(posedge hclk);
            xfer(1'b0, TMC_OFF_COUNT, 32'h0);
            chkr("count prescaled", 32'h3, k < 2 ? 32'h4 : 32'h3, rd);
        end
        $display("test ratios done");
        // hand prescaler to watchdog in order, then count the pin
        xfer(1'b1, TMC_OFF_COUNT, 32'h0);
        xfer(1'b1, TMC_OFF_CTRL, 32'h8);
        xfer(1'b1, TMC_OFF_CTRL, 32'hC);
        for (int e = 0; e < 2; e++) begin
            tmc_pin_model_i.level(1'b0);
            xfer(1'b1, TMC_OFF_CTRL, 32'h2C | (e << 4));
            xfer(1'b1, TMC_OFF_COUNT, 32'h0);
            repeat (12) @(posedge hclk);
            tmc_pin_model_i.pulses(3);
            tmc_pin_model_i.level(1'b1);
            repeat (16) @(posedge hclk);
            rdc("pin edges", TMC_OFF_COUNT, e ? 32'h3 : 32'h4);
        end
        tmc_pin_model_i.level(1'b0);
        $display("test pin count done");
        // overflow sets sticky flag, masked then unmasked
        xfer(1'b1, TMC_OFF_CTRL, 32'h8);
        xfer(1'b1, TMC_OFF_MASK, 32'h0);
        xfer(1'b1, TMC_OFF_COUNT, 32'hFE);
        repeat (24) @(posedge hclk);
        xfer(1'b0, TMC_OFF_STATUS, 32'h0);
        chk("flag set", 32'h1, rd & 32'h1);
        chk("watchdog tick flag", 32'h2, rd & 32'h2);
        chk("irq masked", 32'h0, {31'h0, irq});
        xfer(1'b1, TMC_OFF_STATUS, 32'h0);
        xfer(1'b0, TMC_OFF_STATUS, 32'h0);
        chk("flag kept", 32'h1, rd & 32'h1);
        xfer(1'b1, TMC_OFF_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        xfer(1'b1, TMC_OFF_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test overflow done");
        // sleep freezes the count
        xfer(1'b1, TMC_OFF_CTRL, 32'h48);
        xfer(1'b0, TMC_OFF_COUNT, 32'h0);
        v = rd[7:0];
        repeat (40) @(posedge hclk);
        rdc("count in sleep", TMC_OFF_COUNT, {24'h0, v});
        // unmask the pending watchdog flag: sleep must keep irq low
        xfer(1'b1, TMC_OFF_MASK, 32'h3);
        repeat (2) @(posedge hclk);
        chk("irq in sleep", 32'h0, {31'h0, irq});
        $display("test sleep done");
        // reset in mid-run restores defaults
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        chk("irq in reset", 32'h0, {31'h0, irq});
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("ctrl after reset", TMC_OFF_CTRL, 32'hF);
        rdc("mask after reset", TMC_OFF_MASK, 32'h0);
        $display("test reset done");
        results();
    end
endmodule : tb_top

bind tmc_timer tmc_assertions tmc_assertions_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .wdog_tick, .irq);

//--- bench/tmc_assertions.sv
`timescale 1ns/1ps

// port-level checker for the timer block
module tmc_assertions
    import tmc_pkg::*;
(
    input wire logic        hclk,       // clock
    input wire logic        hresetn,    // async reset, active low
    input wire logic        hsel,       // slave select
    input wire logic [7:0]  haddr,      // byte address
    input wire logic [1:0]  htrans,     // transfer type
    input wire logic        hwrite,     // write strobe
    input wire logic        hready,     // bus ready
    input wire logic [31:0] hwdata,     // write data
    input wire logic [31:0] hrdata,     // read data
    input wire logic        hreadyout,  // slave ready
    input wire logic        hresp,      // response
    input wire logic        wdog_tick,  // watchdog pulse
    input wire logic        irq         // interrupt level
);
    logic       dp_rd;     // read data phase
    logic       dp_wr;     // write data phase
    logic [7:0] dp_a;      // data phase address
    logic [7:0] prev_v;    // last count read
    logic [2:0] prev_age;  // cycles since that read
    logic [7:0] wr_v;      // last count written
    logic [3:0] wr_age;    // cycles since that write
    logic       mz;        // mask known zero
    logic       mz_q;      // mask zero one cycle ago
    wire        take   = hsel && hready && htrans[1];
    wire        rd_cnt = dp_rd && (dp_a == TMC_OFF_COUNT);
    wire        wr_cnt = dp_wr && (dp_a == TMC_OFF_COUNT);

    // track bus phases and last values seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_rd    <= 1'b0;
            dp_wr    <= 1'b0;
            dp_a     <= 8'h00;
            prev_v   <= 8'h00;
            prev_age <= 3'h7;
            wr_v     <= 8'h00;
            wr_age   <= 4'hF;
            mz       <= 1'b1;
            mz_q     <= 1'b1;
        end else begin
            dp_rd    <= take && !hwrite;
            dp_wr    <= take && hwrite;
            dp_a     <= haddr;
            prev_age <= (rd_cnt || prev_age != 3'h7) ? (rd_cnt ? 3'h0 : prev_age + 3'h1) : 3'h7;
            if (rd_cnt) prev_v <= hrdata[7:0];
            wr_age   <= wr_cnt ? 4'h0 : (wr_age == 4'hF ? 4'hF : wr_age + 4'h1);
            if (wr_cnt) wr_v <= hwdata[7:0];
            if (dp_wr && dp_a == TMC_OFF_MASK) mz <= (hwdata[1:0] == 2'h0);
            mz_q     <= mz;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ready_high_a: assert property (hreadyout == 1'b1) else $error("slave ready dropped");
    resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
    rdata_idle_a: assert property (!dp_rd |-> hrdata == 32'h0) else $error("read data outside data phase");
    count_width_a: assert property (rd_cnt |-> hrdata[31:8] == 24'h0) else $error("count wider than byte");
    unmapped_zero_a: assert property (dp_rd && dp_a > TMC_OFF_WDOG |-> hrdata == 32'h0)
        else $error("hidden place read nonzero");
    tick_pulse_a: assert property (wdog_tick |=> !wdog_tick) else $error("watchdog tick too long");
    count_step_a: assert property (rd_cnt && prev_age <= 3'h3 |-> (hrdata[7:0] - prev_v) <= 8'h01)
        else $error("count jumped more than one");
    write_hold_a: assert property (rd_cnt && wr_age < 4'h4 |-> hrdata[7:0] == wr_v)
        else $error("count moved during hold-off");
    irq_masked_a: assert property (mz && mz_q |-> !irq) else $error("interrupt with mask clear");

    cover property (rd_cnt && wr_age < 4'h4);
    cover property (wdog_tick);
    cover property (irq);
endmodule : tmc_assertions

//--- bench/tmc_pin_model.sv
`timescale 1ns/1ps

// external count source driving the count pin
module tmc_pin_model (
    input  wire logic hclk,  // bench clock
    output logic      pin    // count pin level
);
    initial pin = 1'b0;  // idle low

    // set a steady level after the next edge
    task automatic level(input logic v);
        @(posedge hclk);
        pin <= v;
    endtask : level

    // whole pulses, eight clocks high and low each
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (8) @(posedge hclk);
            pin <= 1'b1;
            repeat (8) @(posedge hclk);
            pin <= 1'b0;
        end
    endtask : pulses
endmodule : tmc_pin_model

//--- core/tmc_pkg.sv
package tmc_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TMC_OFF_COUNT  = 8'h00;  // counter_value_reg
    localparam logic [7:0] TMC_OFF_CTRL   = 8'h04;  // control bits
    localparam logic [7:0] TMC_OFF_STATUS = 8'h08;  // sticky events, w1c
    localparam logic [7:0] TMC_OFF_MASK   = 8'h0C;  // interrupt mask
    localparam logic [7:0] TMC_OFF_WDOG   = 8'h10;  // watchdog prescaler tap offset; not decoded, reads zero

    // ------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------
    localparam int TMC_CTL_RATE_LSB = 0;  // prescale_rate[2:0]
    localparam int TMC_CTL_ASSIGN   = 3;  // prescaler_assign
    localparam int TMC_CTL_EDGE     = 4;  // source_edge_select (1 = falling)
    localparam int TMC_CTL_SOURCE   = 5;  // clock_source_select
    localparam int TMC_CTL_SLEEP    = 6;  // sleep request

    // ------------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------------
    localparam int TMC_ST_OVF = 0;  // overflow_flag
    localparam int TMC_ST_WRP = 1;  // prescaler wrap while serving watchdog

    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] TMC_RST_COUNT = 8'h00;  // counter after reset
    localparam logic [6:0] TMC_RST_CTRL  = 7'h0F;  // prescaler to watchdog, rate 111
    localparam logic [1:0] TMC_RST_MASK  = 2'h0;   // all masked
    localparam logic [1:0] TMC_INHIBIT_CYCLES = 2'h2;  // hold-off after counter write
    localparam logic [1:0] TMC_PHASES   = 2'h3;    // last phase index of a cycle

    // ------------------------------------------------------------------
    // ahb constants
    // ------------------------------------------------------------------
    localparam logic [1:0] TMC_HTRANS_NONSEQ = 2'h2;  // nonsequential
    localparam logic [1:0] TMC_HTRANS_SEQ    = 2'h3;  // sequential

endpackage : tmc_pkg

//--- core/tmc_prescaler.sv
`timescale 1ns/1ps

// hidden 8-bit ripple-style prescaler; tick per selected ratio
module tmc_prescaler #(
    parameter int WIDTH = 8                      // prescaler stages
) (
    input  wire logic             hclk,          // clock
    input  wire logic             hresetn,       // async reset, active low
    input  wire logic             clr,           // synchronous clear
    input  wire logic             step,          // one source event
    input  wire logic [2:0]       rate,          // ratio select 2^(k+1)
    output logic                  tick,          // one-cycle divided pulse
    output logic [WIDTH-1:0]      value          // raw count for watchdog tap
);
    import tmc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] cnt;                   // prescale count
        logic             tick;                  // registered tick
    } tmc_psc_s;

    tmc_psc_s st_r;                              // current state
    tmc_psc_s st_nxt;                            // next state
    logic [WIDTH-1:0] lowmask;                   // bits up to and including selected tap

    // ------------------------------------------------------------------
    // tap mask per bit
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_mask
            assign lowmask[gi] = (gi <= int'(rate));  // RULE16
        end
    endgenerate

    // next state: counts every source event, clears on request
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (clr) begin
            st_nxt.cnt = '0;                     // RULE11
        end else if (step) begin
            st_nxt.cnt = st_r.cnt + 1'b1;        // RULE17
            // tick when all bits up to the tap roll to zero
            st_nxt.tick = ((st_r.cnt & lowmask) == lowmask);  // RULE8
        end
    end

    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick  = st_r.tick;
    assign value = st_r.cnt;

endmodule : tmc_prescaler

//--- core/tmc_timer.sv
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: 8-bit counter, software read and write
// RULE2: source clear counts instruction cycles
// RULE3: counter write inhibits two cycles
// RULE4: edge select picks rising or falling
// RULE5: source set counts external pin
// RULE6: one prescaler, timer or watchdog
// RULE7: assign clear gives prescaler to timer
// RULE8: eight ratios, 1:2 to 1:256
// RULE9: assign set gives timer 1:1
// RULE10: prescaler count not software visible
// RULE11: counter write clears assigned prescaler
// RULE12: software order when moving prescaler
// RULE13: wrap sets sticky flag, software clears
// RULE14: external events sampled at phases two, four
// RULE15: sleep freezes counter, no wake
// RULE16: rate k divides by 2^(k+1)
// RULE17: increment per prescaler tick
module tmc_timer #(
    parameter int PSC_WIDTH = 8                          // prescaler stages
) (
    input  wire logic                 hclk,              // 125 MHz clock
    input  wire logic                 hresetn,           // async reset, active low
    input  wire logic                 hsel,              // slave select
    input  wire logic [7:0]           haddr,             // byte address
    input  wire logic [1:0]           htrans,            // transfer type
    input  wire logic                 hwrite,            // write strobe
    input  wire logic [2:0]           hsize,             // transfer size
    input  wire logic                 hready,            // bus ready in
    input  wire logic [31:0]          hwdata,            // write data
    output logic [31:0]               hrdata,            // read data
    output logic                      hreadyout,         // slave ready
    output logic                      hresp,             // response, always okay
    input  wire logic                 external_count_input,  // count pin
    output logic                      wdog_tick,         // prescaled watchdog pulse
    output logic                      irq                // level interrupt
);
    import tmc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  counter_value;                      // count
        logic [6:0]  ctrl;                               // control bits
        logic [1:0]  status;                             // sticky events
        logic [1:0]  mask;                               // interrupt enables
        logic [1:0]  inhibit;                            // remaining hold-off cycles
        logic [1:0]  phase;                              // phase within instr cycle
        logic        pin_s;                              // sampled pin
        logic        pin_d;                              // previous sample
        logic        pend;                               // edge waiting for phase
        logic        dph_valid;                          // data phase pending
        logic        dph_write;                          // pending is write
        logic [7:0]  dph_addr;                           // pending address
        logic [31:0] rdata;                              // read data
        logic        irq;                                // interrupt out
        logic        wdog_tick;                          // watchdog pulse out
    } tmc_state_s;

    tmc_state_s st_r;                                    // current state
    tmc_state_s st_nxt;                                  // next state

    // ------------------------------------------------------------------
    // decoded control
    // ------------------------------------------------------------------
    logic [2:0]           prescale_rate;                 // ratio field
    logic                 prescaler_assign;              // 1 = watchdog
    logic                 source_edge_select;            // 1 = falling edge
    logic                 clock_source_select;           // 1 = external pin
    logic                 sleep_req;                     // processor sleeping
    logic                 addr_ok;                       // valid address phase
    logic                 cnt_wr;                        // counter written now
    logic                 instr_cycle;                   // one instruction cycle
    logic                 edge_hit;                      // active pin edge seen
    logic                 src_event;                     // selected source event
    logic                 psc_step;                      // prescaler input
    logic                 psc_clr;                       // prescaler clear
    logic                 psc_tick;                      // prescaler output
    logic                 inc;                           // counter increment

    assign prescale_rate       = st_r.ctrl[TMC_CTL_RATE_LSB +: 3];
    assign prescaler_assign    = st_r.ctrl[TMC_CTL_ASSIGN];
    assign source_edge_select  = st_r.ctrl[TMC_CTL_EDGE];
    assign clock_source_select = st_r.ctrl[TMC_CTL_SOURCE];
    assign sleep_req           = st_r.ctrl[TMC_CTL_SLEEP];

    assign addr_ok = hsel && hready && (htrans == TMC_HTRANS_NONSEQ || htrans == TMC_HTRANS_SEQ);
    assign cnt_wr  = st_r.dph_valid && st_r.dph_write && (st_r.dph_addr == TMC_OFF_COUNT);

    // ------------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------------
    // four clocks make one instruction cycle, phases 0..3
    assign instr_cycle = (st_r.phase == TMC_PHASES);
    // active edge by polarity select
    assign edge_hit = source_edge_select ? (st_r.pin_d && !st_r.pin_s)   // RULE4
                                         : (!st_r.pin_d && st_r.pin_s);
    // pending edge released only on phase two or four
    assign src_event = clock_source_select ? (st_r.pend && st_r.phase[0])  // RULE5 RULE14
                                           : instr_cycle;                   // RULE2

    // frozen while sleeping: nothing steps
    assign psc_step = src_event && !sleep_req;                              // RULE15
    // clear on counter write only while serving the timer
    assign psc_clr  = cnt_wr && !prescaler_assign;                          // RULE11

    // one prescaler, served to timer or watchdog
    tmc_prescaler #(
        .WIDTH (PSC_WIDTH)
    ) u_psc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clr     (psc_clr),
        .step    (psc_step),
        .rate    (prescale_rate),
        .tick    (psc_tick),
        .value   ()                                      // count stays hidden here
    );

    // timer sees divided tick or the raw event
    assign inc = prescaler_assign ? psc_step                                // RULE6 RULE9
                                  : psc_tick;                               // RULE7 RULE17

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt           = st_r;
        st_nxt.wdog_tick = psc_tick && prescaler_assign;                    // RULE6
        // phase counter runs always
        st_nxt.phase = st_r.phase + 2'h1;
        // pin sampling
        st_nxt.pin_s = external_count_input;
        st_nxt.pin_d = st_r.pin_s;
        if (edge_hit) begin
            st_nxt.pend = 1'b1;
        end else if (st_r.phase[0]) begin
            st_nxt.pend = 1'b0;                                             // RULE14
        end
        // hold-off count down per instruction cycle
        if (st_r.inhibit != 2'h0 && instr_cycle) begin
            st_nxt.inhibit = st_r.inhibit - 2'h1;
        end
        // counter increment with wrap event
        if (inc && st_r.inhibit == 2'h0) begin                              // RULE3
            st_nxt.counter_value = st_r.counter_value + 8'h01;              // RULE1
            if (st_r.counter_value == 8'hFF) begin
                st_nxt.status[TMC_ST_OVF] = 1'b1;                           // RULE13
            end
        end
        // prescaler wrap while serving watchdog
        // data phase writes
        if (st_r.dph_valid && st_r.dph_write) begin
            unique case (st_r.dph_addr)
                TMC_OFF_COUNT: begin
                    st_nxt.counter_value = hwdata[7:0];                     // RULE1
                    st_nxt.inhibit       = TMC_INHIBIT_CYCLES;              // RULE3
                end
                TMC_OFF_CTRL: begin
                    st_nxt.ctrl = hwdata[6:0];
                end
                TMC_OFF_STATUS: begin
                    // write one clears; hardware set below wins
                    st_nxt.status = st_nxt.status & ~hwdata[1:0];
                end
                TMC_OFF_MASK: begin
                    st_nxt.mask = hwdata[1:0];
                end
                default: begin
                end
            endcase
        end
        // events re-applied so set beats clear
        if (inc && st_r.inhibit == 2'h0 && st_r.counter_value == 8'hFF) begin
            st_nxt.status[TMC_ST_OVF] = 1'b1;                               // RULE13
        end
        if (st_nxt.wdog_tick) begin
            st_nxt.status[TMC_ST_WRP] = 1'b1;
        end
        // address phase capture
        st_nxt.dph_valid = addr_ok;
        st_nxt.dph_write = hwrite;
        st_nxt.dph_addr  = haddr;
        // read data, prescaler count never mapped
        st_nxt.rdata = 32'h0000_0000;                                       // RULE10
        if (addr_ok && !hwrite) begin
            unique case (haddr)
                TMC_OFF_COUNT:  st_nxt.rdata = {24'h00_0000, st_nxt.counter_value};
                TMC_OFF_CTRL:   st_nxt.rdata = {25'h000_0000, st_nxt.ctrl};
                TMC_OFF_STATUS: st_nxt.rdata = {30'h0000_0000, st_nxt.status};
                TMC_OFF_MASK:   st_nxt.rdata = {30'h0000_0000, st_nxt.mask};
                default:        st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // interrupt level, no wake while sleeping
        st_nxt.irq = |(st_nxt.status & st_nxt.mask) && !st_nxt.ctrl[TMC_CTL_SLEEP];  // RULE15
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r               <= '0;
            st_r.counter_value <= TMC_RST_COUNT;
            st_r.ctrl          <= TMC_RST_CTRL;
            st_r.mask          <= TMC_RST_MASK;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hrdata    = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = st_r.irq;
    assign wdog_tick = st_r.wdog_tick;

endmodule : tmc_timer
